// ==== core/rsbs_bs_advance.sv ====
// Backing-store address advance: base plus count register slots,
// skipping the collection words that fall in between.
// Assumes count never exceeds the physical stacked register count.
`timescale 1ns/1ns
module rsbs_bs_advance (
  input wire logic [63:0] base_i,
  input wire logic [6:0] count_i,
  output logic [63:0] result_o
);

  wire logic [7:0] slot_sum;
  wire logic [7:0] skipped;
  wire logic [7:0] total_slots;

  // Every 63 data slots one collection word is inserted
  assign slot_sum = {2'b00, base_i[rsbs_pkg::SLOT_MSB:rsbs_pkg::SLOT_LSB]} + {1'b0, count_i};
  assign skipped = slot_sum / rsbs_pkg::SLOTS_PER_GROUP;
  assign total_slots = {1'b0, count_i} + skipped;
  assign result_o = base_i + {53'h0, total_slots, 3'h0};

endmodule

// ==== core/rsbs_engine.sv ====
// Register stack backing-store engine: frame bookkeeping and spill steps.
// Assumes the register file supplies spill data for spill_reg_index_o in the
// same cycle and that memory answers each spill with one ack or err pulse.
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ns
module rsbs_engine (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [63:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [63:0] reg_rdata_o,
  input wire logic op_valid_i,
  input wire logic [2:0] op_code_i,
  input wire logic [6:0] op_size_i,
  input wire logic intr_i,
  output logic op_ready_o,
  output logic op_done_o,
  output logic op_aborted_o,
  output logic [6:0] spill_reg_index_o,
  input wire logic [63:0] spill_data_i,
  input wire logic spill_nat_i,
  output logic mem_req_o,
  output logic [63:0] mem_addr_o,
  output logic [63:0] mem_data_o,
  output logic [1:0] mem_pl_o,
  output logic mem_byte_order_o,
  output logic mem_advanced_load_table_inval_o,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  output logic current_frame_load_enable_o,
  output logic [6:0] rename_base_o,
  output logic [6:0] frame_size_o
);

  // Index arithmetic modulo the stacked register count
  function automatic logic [6:0] wrap_add(input logic [6:0] idx, input logic [6:0] amt);
    logic [7:0] sum;
    sum = {1'b0, idx} + {1'b0, amt};
    if (sum >= {1'b0, rsbs_pkg::NUM_STACKED}) begin
      sum = sum - {1'b0, rsbs_pkg::NUM_STACKED};
    end
    return sum[6:0];
  endfunction

  rsbs_pkg::rsbs_state_e state;
  rsbs_pkg::rsbs_state_e next_state;

  logic [63:0] store_pointer;
  logic [63:0] stack_top_address;
  logic [63:0] load_pointer;
  logic [63:0] deferred_bit_collection;
  logic [1:0] spill_privilege_level;
  logic [6:0] cur_size;
  logic [6:0] dirty;
  logic [6:0] clean;
  logic [6:0] target_size;
  logic growing;
  logic spill_is_reg;
  logic spill_nat;
  logic intr_seen;

  wire logic [6:0] invalid;
  wire logic [5:0] sp_slot;
  wire logic at_collection;
  wire logic [63:0] top_from_store;
  wire logic [63:0] top_from_preserve;
  wire logic [6:0] preserve_size;
  wire logic [6:0] growth;
  wire logic [7:0] free_regs;
  wire logic need_spill;
  wire logic [6:0] clean_after_grow;
  wire logic sp_write;
  wire logic op_take;
  wire logic spill_ok;
  wire logic spill_fail;
  wire logic [63:0] read_mux;
  wire logic [63:0] status_word;
  wire logic [63:0] next_collection;

  // Invalid partition is whatever is left over
  assign invalid = rsbs_pkg::NUM_STACKED - cur_size - dirty - clean;

  assign sp_slot = store_pointer[rsbs_pkg::SLOT_MSB:rsbs_pkg::SLOT_LSB];
  assign at_collection = (sp_slot == rsbs_pkg::COLLECTION_SLOT);

  rsbs_bs_advance u_top_from_store (
    .base_i(reg_wdata_i),
    .count_i(dirty),
    .result_o(top_from_store)
  );

  // A preserve larger than the frame is clamped to the frame
  assign preserve_size = (op_size_i > cur_size) ? cur_size : op_size_i;

  rsbs_bs_advance u_top_from_preserve (
    .base_i(stack_top_address),
    .count_i(preserve_size),
    .result_o(top_from_preserve)
  );

  // Growth is measured against the target of the pending new frame
  assign growth = (target_size > cur_size) ? (target_size - cur_size) : 7'h00;
  assign free_regs = {1'b0, invalid} + {1'b0, clean};
  assign need_spill = growing && (free_regs < {1'b0, growth}) && (dirty != 7'h00);
  // Growth draws on invalid registers first, then clean ones
  assign clean_after_grow = (growth > invalid) ? (clean - (growth - invalid)) : clean;

  assign sp_write = reg_wr_i && (reg_addr_i == rsbs_pkg::REG_STORE_PTR) && (state == rsbs_pkg::RSBS_IDLE);
  assign op_take = op_valid_i && (state == rsbs_pkg::RSBS_IDLE) && !sp_write;
  assign spill_ok = (state == rsbs_pkg::RSBS_WAIT) && mem_ack_i;
  assign spill_fail = (state == rsbs_pkg::RSBS_WAIT) && !mem_ack_i && mem_err_i;

  // Hardware deposit wins over a software write in the same cycle
  assign next_collection = (spill_ok && spill_is_reg)
    ? (deferred_bit_collection | ({63'h0, spill_nat} << mem_addr_o[rsbs_pkg::SLOT_MSB:rsbs_pkg::SLOT_LSB]))
      & ~(({63'h0, ~spill_nat}) << mem_addr_o[rsbs_pkg::SLOT_MSB:rsbs_pkg::SLOT_LSB])
    : (reg_wr_i && reg_addr_i == rsbs_pkg::REG_COLLECTION) ? reg_wdata_i
    : deferred_bit_collection;

  assign status_word = ({63'h0, current_frame_load_enable_o} << rsbs_pkg::STAT_CFLE)
    | ({63'h0, state != rsbs_pkg::RSBS_IDLE} << rsbs_pkg::STAT_BUSY)
    | ({57'h0, cur_size} << rsbs_pkg::STAT_CUR_LSB)
    | ({57'h0, dirty} << rsbs_pkg::STAT_DIRTY_LSB)
    | ({57'h0, clean} << rsbs_pkg::STAT_CLEAN_LSB)
    | ({57'h0, invalid} << rsbs_pkg::STAT_INVALID_LSB)
    | ({57'h0, spill_reg_index_o} << rsbs_pkg::STAT_STIDX_LSB)
    | ({57'h0, rename_base_o} << rsbs_pkg::STAT_RENAME_LSB);

  assign read_mux = (reg_addr_i == rsbs_pkg::REG_STORE_PTR) ? store_pointer
    : (reg_addr_i == rsbs_pkg::REG_STACK_TOP) ? stack_top_address
    : (reg_addr_i == rsbs_pkg::REG_LOAD_PTR) ? load_pointer
    : (reg_addr_i == rsbs_pkg::REG_COLLECTION) ? deferred_bit_collection
    : (reg_addr_i == rsbs_pkg::REG_CONFIG) ? {62'h0, spill_privilege_level}
    : (reg_addr_i == rsbs_pkg::REG_STATUS) ? status_word
    : 64'h0;

  // Sequencer for spills, both single and frame-growth driven
  always_comb begin
    next_state = state;
    unique case (state)
      rsbs_pkg::RSBS_IDLE: begin
        if (op_take && op_code_i == rsbs_pkg::OP_STORE) begin
          next_state = rsbs_pkg::RSBS_ISSUE;
        end else if (op_take && op_code_i == rsbs_pkg::OP_NEW_FRAME) begin
          next_state = rsbs_pkg::RSBS_CHECK;
        end
      end
      rsbs_pkg::RSBS_ISSUE: begin
        next_state = rsbs_pkg::RSBS_WAIT;
      end
      rsbs_pkg::RSBS_WAIT: begin
        if (spill_fail || (spill_ok && !growing)) begin
          next_state = rsbs_pkg::RSBS_IDLE;
        end else if (spill_ok) begin
          next_state = rsbs_pkg::RSBS_CHECK;
        end
      end
      rsbs_pkg::RSBS_CHECK: begin
        if (need_spill && !intr_seen) begin
          next_state = rsbs_pkg::RSBS_ISSUE;
        end else begin
          next_state = rsbs_pkg::RSBS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= rsbs_pkg::RSBS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Register port: read data stands in each cycle after a cycle with the read strobe, zero otherwise
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= rsbs_pkg::RST_PTR;
    end else begin
      reg_rdata_o <= reg_rd_i ? read_mux : 64'h0;
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      load_pointer <= rsbs_pkg::RST_PTR;
      spill_privilege_level <= rsbs_pkg::RST_PL;
      deferred_bit_collection <= rsbs_pkg::RST_PTR;
    end else begin
      if (reg_wr_i && reg_addr_i == rsbs_pkg::REG_LOAD_PTR) begin
        load_pointer <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == rsbs_pkg::REG_CONFIG) begin
        spill_privilege_level <= reg_wdata_i[rsbs_pkg::CFG_PL_LSB +: 2];
      end
      deferred_bit_collection <= next_collection;
    end
  end

  // Store pointer: software write or post-spill advance
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      store_pointer <= rsbs_pkg::RST_PTR;
    end else if (sp_write) begin
      store_pointer <= reg_wdata_i;
    end else if (spill_ok) begin
      store_pointer <= store_pointer + rsbs_pkg::SPILL_STRIDE;
    end
  end

  // Stack top address follows store pointer writes and preserves
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      stack_top_address <= rsbs_pkg::RST_PTR;
    end else if (sp_write) begin
      stack_top_address <= top_from_store;
    end else if (op_take && op_code_i == rsbs_pkg::OP_PRESERVE) begin
      stack_top_address <= top_from_preserve;
    end
  end

  // Only the explicit compare sets the enable; nothing is launched from it
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      current_frame_load_enable_o <= 1'b0;
    end else if (op_take && op_code_i == rsbs_pkg::OP_ENABLE_CFL) begin
      current_frame_load_enable_o <= (load_pointer > stack_top_address);
    end
  end

  // Partition bookkeeping; the four counts always sum to the register count
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cur_size <= rsbs_pkg::RST_CNT;
      dirty <= rsbs_pkg::RST_CNT;
      clean <= rsbs_pkg::RST_CNT;
      rename_base_o <= rsbs_pkg::RST_CNT;
    end else if (sp_write) begin
      clean <= rsbs_pkg::RST_CNT;
    end else if (op_take && op_code_i == rsbs_pkg::OP_INVALIDATE) begin
      dirty <= rsbs_pkg::RST_CNT;
      clean <= rsbs_pkg::RST_CNT;
    end else if (op_take && op_code_i == rsbs_pkg::OP_PRESERVE) begin
      cur_size <= cur_size - preserve_size;
      dirty <= dirty + preserve_size;
      rename_base_o <= wrap_add(rename_base_o, preserve_size);
    end else if (spill_ok && spill_is_reg) begin
      dirty <= dirty - 7'h01;
      clean <= clean + 7'h01;
    end else if (state == rsbs_pkg::RSBS_CHECK && !need_spill) begin
      // Frame is resized only once enough registers are free; renaming untouched
      cur_size <= target_size;
      clean <= clean_after_grow;
    end
  end

  // New-frame request: the size replaces any earlier request
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      target_size <= rsbs_pkg::RST_CNT;
      growing <= 1'b0;
      intr_seen <= 1'b0;
    end else if (op_take) begin
      target_size <= (op_size_i > rsbs_pkg::NUM_STACKED) ? rsbs_pkg::NUM_STACKED : op_size_i;
      growing <= (op_code_i == rsbs_pkg::OP_NEW_FRAME);
      intr_seen <= 1'b0;
    end else if (next_state == rsbs_pkg::RSBS_IDLE) begin
      growing <= 1'b0;
      intr_seen <= 1'b0;
    end else if (intr_i && growing) begin
      // The outstanding spill finishes before the sequence stops
      intr_seen <= 1'b1;
    end
  end

  // Spill issue: address, data and attributes latched for the memory
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      mem_req_o <= 1'b0;
      mem_addr_o <= rsbs_pkg::RST_PTR;
      mem_data_o <= rsbs_pkg::RST_PTR;
      mem_pl_o <= rsbs_pkg::RST_PL;
      mem_byte_order_o <= rsbs_pkg::MANDATORY_BYTE_ORDER;
      mem_advanced_load_table_inval_o <= 1'b0;
      spill_is_reg <= 1'b0;
      spill_nat <= 1'b0;
    end else if (state == rsbs_pkg::RSBS_ISSUE) begin
      mem_req_o <= 1'b1;
      mem_addr_o <= store_pointer;
      mem_data_o <= at_collection ? deferred_bit_collection : spill_data_i;
      mem_pl_o <= spill_privilege_level;
      mem_byte_order_o <= rsbs_pkg::MANDATORY_BYTE_ORDER;
      mem_advanced_load_table_inval_o <= 1'b0;
      spill_is_reg <= !at_collection;
      spill_nat <= spill_nat_i;
    end else if (spill_ok || spill_fail) begin
      mem_req_o <= 1'b0;
    end
  end

  // Store register index wraps within the stacked range
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      spill_reg_index_o <= rsbs_pkg::RST_CNT;
    end else if (spill_ok && spill_is_reg) begin
      spill_reg_index_o <= wrap_add(spill_reg_index_o, 7'h01);
    end
  end

  // Completion pulses and handshake level
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      op_ready_o <= 1'b0;
      op_done_o <= 1'b0;
      op_aborted_o <= 1'b0;
      frame_size_o <= rsbs_pkg::RST_CNT;
    end else begin
      op_ready_o <= (next_state == rsbs_pkg::RSBS_IDLE);
      op_done_o <= (state != rsbs_pkg::RSBS_IDLE && next_state == rsbs_pkg::RSBS_IDLE)
        || (op_take && op_code_i != rsbs_pkg::OP_STORE && op_code_i != rsbs_pkg::OP_NEW_FRAME);
      op_aborted_o <= spill_fail || (state == rsbs_pkg::RSBS_CHECK && intr_seen && need_spill);
      frame_size_o <= cur_size;
    end
  end

endmodule

// ==== core/rsbs_pkg.sv ====
// Constants shared by the register stack backing-store engine.
// Assumes a 64-bit backing-store address space and 96 physical stacked registers.
package rsbs_pkg;

  localparam int unsigned ADDR_W = 64;
  localparam int unsigned DATA_W = 64;
  localparam int unsigned CNT_W = 7;
  localparam logic [6:0] NUM_STACKED = 7'h60;

  // Register map, word index on the 4-bit register port
  localparam logic [3:0] REG_STORE_PTR = 4'h0;
  localparam logic [3:0] REG_STACK_TOP = 4'h1;
  localparam logic [3:0] REG_LOAD_PTR = 4'h2;
  localparam logic [3:0] REG_COLLECTION = 4'h3;
  localparam logic [3:0] REG_CONFIG = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h5;

  // Config and status field positions
  localparam int unsigned CFG_PL_LSB = 0;
  localparam int unsigned STAT_CFLE = 0;
  localparam int unsigned STAT_BUSY = 1;
  localparam int unsigned STAT_CUR_LSB = 8;
  localparam int unsigned STAT_DIRTY_LSB = 16;
  localparam int unsigned STAT_CLEAN_LSB = 24;
  localparam int unsigned STAT_INVALID_LSB = 32;
  localparam int unsigned STAT_STIDX_LSB = 40;
  localparam int unsigned STAT_RENAME_LSB = 48;

  // Collection slot: address bits 8:3 all ones
  localparam int unsigned SLOT_LSB = 3;
  localparam int unsigned SLOT_MSB = 8;
  localparam logic [5:0] COLLECTION_SLOT = 6'h3F;
  localparam logic [7:0] SLOTS_PER_GROUP = 8'h3F;
  localparam logic [63:0] SPILL_STRIDE = 64'h0000_0000_0000_0008;

  // Fixed byte order of every spill: 0 = little endian
  localparam logic MANDATORY_BYTE_ORDER = 1'b0;

  // Reset values
  localparam logic [63:0] RST_PTR = 64'h0000_0000_0000_0000;
  localparam logic [1:0] RST_PL = 2'h0;
  localparam logic [6:0] RST_CNT = 7'h00;

  // Operation codes on op_code_i
  localparam logic [2:0] OP_ENABLE_CFL = 3'h1;
  localparam logic [2:0] OP_INVALIDATE = 3'h2;
  localparam logic [2:0] OP_NEW_FRAME = 3'h3;
  localparam logic [2:0] OP_PRESERVE = 3'h4;
  localparam logic [2:0] OP_STORE = 3'h5;

  typedef enum logic [1:0] {
    RSBS_IDLE = 2'b00,
    RSBS_ISSUE = 2'b01,
    RSBS_WAIT = 2'b10,
    RSBS_CHECK = 2'b11
  } rsbs_state_e;

endpackage

// ==== verification/rsbs_engine_assertions.sv ====
// Port checks of the engine's spill handshake and frame bookkeeping.
// Sees only ports of rsbs_engine; attached by the bind at the foot.
`timescale 1ns/1ns
module rsbs_engine_assertions (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic op_valid_i,
  input wire logic [2:0] op_code_i,
  input wire logic op_done_o,
  input wire logic op_aborted_o,
  input wire logic [6:0] spill_reg_index_o,
  input wire logic mem_req_o,
  input wire logic [63:0] mem_addr_o,
  input wire logic [63:0] mem_data_o,
  input wire logic mem_byte_order_o,
  input wire logic mem_advanced_load_table_inval_o,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  input wire logic current_frame_load_enable_o,
  input wire logic [6:0] rename_base_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire pres = op_valid_i && op_code_i == rsbs_pkg::OP_PRESERVE;
  sequence s_ok; mem_req_o && mem_ack_i; endsequence
  sequence s_bad; mem_req_o && mem_err_i && !mem_ack_i; endsequence
  sequence s_wait; mem_req_o && !mem_ack_i && !mem_err_i; endsequence
  property p_order; mem_byte_order_o == 1'b0; endproperty
  property p_advanced_load_table; mem_advanced_load_table_inval_o == 1'b0; endproperty
  property p_hold; s_wait |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_data_o); endproperty
  property p_idx; s_ok ##0 (mem_addr_o[8:3] != 6'h3F) |=>
    spill_reg_index_o == ($past(spill_reg_index_o) == 7'h5F ? 7'h00 : $past(spill_reg_index_o) + 7'h01); endproperty
  property p_slot; s_ok ##0 (mem_addr_o[8:3] == 6'h3F) |=> $stable(spill_reg_index_o); endproperty
  property p_rel; s_ok |=> !mem_req_o; endproperty
  property p_bad; s_bad |=> op_aborted_o && op_done_o && $stable(spill_reg_index_o); endproperty
  property p_cfle; $rose(current_frame_load_enable_o) |-> !mem_req_o && !op_aborted_o; endproperty
  property p_name; !$stable(rename_base_o) |-> $past(pres) || $past(pres, 2); endproperty
  a_order: assert property (p_order) else $error("spill byte order moved");
  a_advanced_load_table: assert property (p_advanced_load_table) else $error("spill touched load table");
  a_hold: assert property (p_hold) else $error("spill request changed before answer");
  a_idx: assert property (p_idx) else $error("store index did not step");
  a_slot: assert property (p_slot) else $error("collection spill moved index");
  a_rel: assert property (p_rel) else $error("request held after ack");
  a_bad: assert property (p_bad) else $error("failed spill not aborted");
  a_cfle: assert property (p_cfle) else $error("load enable started traffic");
  a_name: assert property (p_name) else $error("rename moved outside preserve");
endmodule
bind rsbs_engine rsbs_engine_assertions u_chk (.clock_i, .rst_i, .op_valid_i, .op_code_i, .op_done_o,
  .op_aborted_o, .spill_reg_index_o, .mem_req_o, .mem_addr_o, .mem_data_o, .mem_byte_order_o,
  .mem_advanced_load_table_inval_o, .mem_ack_i, .mem_err_i, .current_frame_load_enable_o, .rename_base_o);

// ==== verification/rsbs_mem_model.sv ====
// Data memory partner that answers the spill port; it keeps no backing-store data.
// Answers each held write request once, after lat_i cycles, with ack or err.
`timescale 1ns/1ns
module rsbs_mem_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic [3:0] lat_i,
  input wire logic fail_i,
  output logic ack_o,
  output logic err_o
);
  logic [3:0] cnt;
  logic done;
  wire fire = req_i && !done && cnt >= lat_i;
  // Done blocks a second answer in the cycle while the engine drops its request
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      done <= 1'b0;
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= fire && !fail_i;
      err_o <= fire && fail_i;
      done <= req_i && (done || fire);
      cnt <= (req_i && !done && cnt < lat_i) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule

// ==== verification/test_register_stack_backing_store.sv ====
// Self-checking bench of rsbs_engine against an integer model of the stack.
// Assumes rsbs_mem_model answers spills; the checker is bound to the engine.
`timescale 1ns/1ns
module test_register_stack_backing_store;
  logic clock_i, rst_i, reg_wr_i, reg_rd_i, op_valid_i, intr_i, spill_nat_i, fail, mon, ab;
  logic op_ready_o, op_done_o, op_aborted_o, mem_req_o, mem_byte_order_o, mem_advanced_load_table_inval_o;
  logic mem_ack_i, mem_err_i, current_frame_load_enable_o, cfle;
  logic [3:0] reg_addr_i, lat;
  logic [2:0] op_code_i;
  logic [1:0] mem_pl_o;
  logic [6:0] op_size_i, spill_reg_index_o, rename_base_o, frame_size_o;
  logic [63:0] reg_wdata_i, reg_rdata_o, spill_data_i, mem_addr_o, mem_data_o, sp, top, coll, ed, rv;
  int err_count, cmp_count, seed, frame, dirty, clean, idx, rnm;
  rsbs_engine dut (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .op_valid_i, .op_code_i, .op_size_i, .intr_i, .op_ready_o, .op_done_o, .op_aborted_o,
    .spill_reg_index_o, .spill_data_i, .spill_nat_i, .mem_req_o, .mem_addr_o, .mem_data_o, .mem_pl_o,
    .mem_byte_order_o, .mem_advanced_load_table_inval_o, .mem_ack_i, .mem_err_i, .current_frame_load_enable_o,
    .rename_base_o, .frame_size_o);
  rsbs_mem_model mem (.clock_i, .rst_i, .req_i(mem_req_o), .lat_i(lat), .fail_i(fail),
    .ack_o(mem_ack_i), .err_o(mem_err_i));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick();
    @(posedge clock_i);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [63:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    tick();
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [63:0] e);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    tick();
    reg_rd_i <= 1'b0;
    chk(reg_rdata_o, e);
  endtask
  task automatic op(input logic [2:0] c, input logic [6:0] s);
    int k;
    k = 0;
    while (op_ready_o !== 1'b1 && k < 300) begin
      tick();
      k++;
    end
    if (k >= 300) begin
      err_count++;
      summarize();
    end
    op_code_i <= c;
    op_size_i <= s;
    op_valid_i <= 1'b1;
    tick();
    op_valid_i <= 1'b0;
    while (op_done_o !== 1'b1 && op_aborted_o !== 1'b1 && k < 600) begin
      tick();
      k++;
    end
    if (k >= 600) begin
      err_count++;
      summarize();
    end
    ab = op_aborted_o;
  endtask
  function automatic logic [63:0] stat();
    stat = 64'h0;
    stat[0] = cfle;
    stat[14:8] = 7'(frame);
    stat[22:16] = 7'(dirty);
    stat[30:24] = 7'(clean);
    stat[38:32] = 7'(96 - frame - dirty - clean);
    stat[46:40] = 7'(idx);
    stat[54:48] = 7'(rnm);
  endfunction
  // Backing-store location n register slots on, stepping over collection words
  function automatic logic [63:0] adv(input logic [63:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      b = b + 64'h8;
      if (b[8:3] == 6'h3F) b = b + 64'h8;
    end
    return b;
  endfunction
  task automatic spill(input logic bad);
    rv = 64'($random(seed));
    lat <= rv[3:0] & 4'h3;
    spill_nat_i <= rv[4];
    spill_data_i <= {rv[31:0], ~rv[31:0]};
    fail <= bad;
    ed = (sp[8:3] == 6'h3F) ? coll : {rv[31:0], ~rv[31:0]};
    mon = !bad;
    op(rsbs_pkg::OP_STORE, 7'h00);
    mon = 1'b0;
    chk(64'(ab), 64'(bad));
    if (!bad && sp[8:3] != 6'h3F) begin
      coll[sp[8:3]] = rv[4];
      idx = (idx + 1) % 96;
      dirty--;
      clean++;
    end
    if (!bad) sp = sp + 64'h8;
  endtask
  always @(posedge clock_i) begin
    if (mon && mem_req_o === 1'b1 && mem_ack_i === 1'b1) begin
      chk(mem_addr_o, sp);
      chk(mem_data_o, ed);
      chk(64'(mem_pl_o), 64'h2);
    end
  end
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, op_valid_i, intr_i, spill_nat_i, fail, mon, cfle} = 9'h100;
    {reg_addr_i, lat, op_code_i, op_size_i, reg_wdata_i, spill_data_i} = 0;
    {err_count, cmp_count, frame, dirty, clean, idx, rnm, seed} = {{7{32'h0}}, 32'h10};
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    tick();
    rd(rsbs_pkg::REG_STATUS, stat());
    rd(4'hF, 64'h0);
    $display("reset state done");
    rv = {$random(seed), $random(seed)};
    coll = rv;
    sp = 64'h1F0;
    top = sp;
    wr(rsbs_pkg::REG_CONFIG, 64'h2);
    wr(rsbs_pkg::REG_COLLECTION, coll);
    wr(rsbs_pkg::REG_STORE_PTR, sp);
    rd(rsbs_pkg::REG_STACK_TOP, top);
    op(rsbs_pkg::OP_NEW_FRAME, 7'd10);
    op(rsbs_pkg::OP_NEW_FRAME, 7'd4);
    frame = 4;
    rd(rsbs_pkg::REG_STATUS, stat());
    chk(64'(frame_size_o), 64'(frame));
    op(rsbs_pkg::OP_PRESERVE, 7'd4);
    frame = 0;
    dirty = 4;
    rnm = 4;
    top = adv(top, 4);
    rd(rsbs_pkg::REG_STACK_TOP, top);
    chk(64'(rename_base_o), 64'h4);
    $display("frame tests done");
    spill(1'b1);
    repeat (5) spill(1'b0);
    rd(rsbs_pkg::REG_STATUS, stat());
    rd(rsbs_pkg::REG_COLLECTION, coll);
    rd(rsbs_pkg::REG_STORE_PTR, sp);
    $display("spill tests done");
    wr(rsbs_pkg::REG_LOAD_PTR, top + 64'h8);
    op(rsbs_pkg::OP_ENABLE_CFL, 7'h00);
    chk(64'(current_frame_load_enable_o), 64'h1);
    wr(rsbs_pkg::REG_LOAD_PTR, top);
    op(rsbs_pkg::OP_ENABLE_CFL, 7'h00);
    chk(64'(current_frame_load_enable_o), 64'h0);
    $display("load enable tests done");
    op(rsbs_pkg::OP_NEW_FRAME, 7'd10);
    op(rsbs_pkg::OP_PRESERVE, 7'd3);
    frame = 7;
    dirty = 3;
    rnm = 7;
    sp = 64'h1000;
    wr(rsbs_pkg::REG_STORE_PTR, sp);
    top = adv(sp, 3);
    clean = 0;
    rd(rsbs_pkg::REG_STACK_TOP, top);
    rd(rsbs_pkg::REG_STATUS, stat());
    spill_nat_i <= 1'b0;
    fail <= 1'b0;
    op(rsbs_pkg::OP_NEW_FRAME, 7'd96);
    chk(64'(ab), 64'h0);
    sp = sp + 64'h18;
    coll[2:0] = 3'h0;
    {idx, dirty, frame} = {32'(idx + 3), 32'h0, 32'd96};
    rd(rsbs_pkg::REG_STATUS, stat());
    rd(rsbs_pkg::REG_STORE_PTR, sp);
    op(rsbs_pkg::OP_NEW_FRAME, 7'd5);
    op(rsbs_pkg::OP_PRESERVE, 7'd2);
    {frame, dirty, rnm} = {32'd3, 32'd2, 32'd9};
    intr_i <= 1'b1;
    op(rsbs_pkg::OP_NEW_FRAME, 7'd96);
    intr_i <= 1'b0;
    chk(64'(ab), 64'h1);
    {dirty, clean, idx} = {32'd1, 32'd1, 32'(idx + 1)};
    rd(rsbs_pkg::REG_STATUS, stat());
    op(rsbs_pkg::OP_INVALIDATE, 7'h00);
    {dirty, clean} = {32'h0, 32'h0};
    rd(rsbs_pkg::REG_STATUS, stat());
    chk(64'(frame_size_o), 64'(frame));
    $display("growth and invalidate tests done");
    summarize();
  end
endmodule
